// *** dv/pcr_bank_chk.sv ***
// assertion checker on the pll control bank ports
`timescale 1ns/10ps
`default_nettype none
module pcr_bank_chk (
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic       spi_sen,
	input wire logic       pfd_up_in,
	input wire logic       pfd_dn_in,
	input wire logic       bias_enable,
	input wire logic       ref_div_hold,
	input wire logic       ref_div_used,
	input wire logic       ref_clk_tick,
	input wire logic       xref_mux_gate,
	input wire logic       div_ref_gate,
	input wire logic       pump_output_enable,
	input wire logic       square_buffer_enable,
	input wire logic       sine_buffer_enable,
	input wire logic       pump_up_pulse,
	input wire logic       pump_dn_pulse,
	input wire logic [2:0] pfd_delay,
	input wire logic [4:0] pump_up_gain
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_hold_no_div: assert property (ref_div_hold |-> !ref_div_used)
		else $error("divider in path while held");
	a_hold_bias: assert property (!bias_enable |-> ref_div_hold)
		else $error("divider released with bias off");
	a_bias_gates: assert property (!bias_enable |-> !(xref_mux_gate || div_ref_gate ||
		pump_output_enable || square_buffer_enable)) else $error("enable on with bias off");
	a_buf_excl: assert property (!(square_buffer_enable && sine_buffer_enable))
		else $error("both reference buffers on");
	a_pump_quiet: assert property (!pump_output_enable [*2] |->
		!(pump_up_pulse || pump_dn_pulse)) else $error("pump pulse while disabled");
	a_pulse_cause: assert property ((pump_up_pulse || pump_dn_pulse) |->
		$past(pfd_up_in || pfd_dn_in)) else $error("pump pulse without detector input");
	a_tick_single: assert property (ref_clk_tick |=> !ref_clk_tick)
		else $error("reference tick longer than one cycle");
	a_field_quiet: assert property (($changed(pfd_delay) || $changed(pump_up_gain)) |->
		$past(spi_sen, 3)) else $error("field changed outside a frame");
	c_tick: cover property (ref_clk_tick);
	c_dn: cover property (pump_dn_pulse);
	c_bias_off: cover property ($fell(bias_enable));
endmodule
bind pcr_bank pcr_bank_chk u_chk (.sys_clk, .rstn, .spi_sen, .pfd_up_in, .pfd_dn_in,
	.bias_enable, .ref_div_hold, .ref_div_used, .ref_clk_tick, .xref_mux_gate, .div_ref_gate,
	.pump_output_enable, .square_buffer_enable, .sine_buffer_enable, .pump_up_pulse,
	.pump_dn_pulse, .pfd_delay, .pump_up_gain);
`default_nettype wire

// *** dv/pcr_host.sv ***
// serial port host model that frames register reads and writes
`timescale 1ns/10ps
`default_nettype none
module pcr_host (
	input  wire logic sys_clk,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output var logic  spi_sclk,
	output var logic  spi_sen,
	output var logic  spi_sdi
);
	logic rd_oe;
	initial begin
		spi_sclk = 1'b0;
		spi_sen = 1'b0;
		spi_sdi = 1'b0;
		rd_oe = 1'b0;
	end
	// flag, six address bits, 24 data bits, msb first; clock idles low
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [23:0] wd,
		input int n, output logic [23:0] q);
		logic [30:0] f;
		int i;
		begin
			f = {rd, a, wd};
			q = 24'h000000;
			@(negedge sys_clk);
			spi_sen = 1'b1;
			for (i = 0; i < n; i++) begin
				spi_sdi = (i < 31) ? f[30 - i] : ~spi_sdi;
				repeat (4) @(negedge sys_clk);
				if (i > 7) q[31 - i] = pin_oe ? pin_o : ~spi_sdi;
				if (i == 20) rd_oe = pin_oe;
				spi_sclk = 1'b1;
				repeat (4) @(negedge sys_clk);
				spi_sclk = 1'b0;
			end
			spi_sen = 1'b0;
			spi_sdi = ~spi_sdi;
			repeat (4) @(negedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the pll control bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %0t got %h exp %h", $time, g, e); end end
module testbench;
	localparam [23:0] ID = 24'h00A5A5; // arbitrary identity value
	logic sys_clk = 1'b0, rstn = 1'b0, xtal_ref_in = 1'b0, lock_detect_in = 1'b0;
	logic pfd_up_in = 1'b0, pfd_dn_in = 1'b0;
	wire spi_sclk, spi_sen, spi_sdi, lock_serial_out_pin_o, lock_serial_out_pin_oe;
	wire vco_buffer_enable, bias_enable, ref_div_hold, ref_div_used, ref_clk_tick;
	wire xref_mux_gate, div_ref_gate, sq_xtal_gate, sin_xtal_gate, square_buffer_enable;
	wire sine_buffer_enable, mod_clk_from_vco, prescaler_enable, lock_detector_enable;
	wire pump_output_enable, modulator_run, lock_circuit_enable, cycle_slip_prevention;
	wire prescaler_duty_mode, pump_up_pulse, pump_dn_pulse;
	wire [2:0] pfd_delay;
	wire [4:0] pump_up_gain, pump_down_gain;
	wire [15:0] gv = {bias_enable, vco_buffer_enable, ~ref_div_hold, sin_xtal_gate,
		sq_xtal_gate, div_ref_gate, xref_mux_gate, sine_buffer_enable, square_buffer_enable,
		mod_clk_from_vco, cycle_slip_prevention, lock_circuit_enable, modulator_run,
		pump_output_enable, lock_detector_enable, prescaler_enable};
	wire [13:0] fv = {pfd_delay, pump_down_gain, pump_up_gain, prescaler_duty_mode};
	int n_errors = 0, comparisons = 0, cycles = 0, ticks = 0, k, p;
	int dn [5] = '{4, 12, 4, 12, 12};
	logic [23:0] r3 [5] = '{24'h004003, 24'h008001, 24'h008003, 24'h000003, 24'h004003};
	logic [23:0] pat [3] = '{24'hFFFFFF, 24'hAAAAAA, 24'h555555};
	logic [23:0] v, q;
	logic [15:0] e, g;
	pcr_bank #(.CHIP_ID(ID)) dut (.sys_clk, .rstn, .spi_sclk, .spi_sen, .spi_sdi,
		.xtal_ref_in, .lock_detect_in, .pfd_up_in, .pfd_dn_in, .lock_serial_out_pin_o,
		.lock_serial_out_pin_oe, .vco_buffer_enable, .bias_enable, .ref_div_hold,
		.ref_div_used, .ref_clk_tick, .xref_mux_gate, .div_ref_gate, .sq_xtal_gate,
		.sin_xtal_gate, .square_buffer_enable, .sine_buffer_enable, .mod_clk_from_vco,
		.prescaler_enable, .lock_detector_enable, .pump_output_enable, .modulator_run,
		.lock_circuit_enable, .cycle_slip_prevention, .prescaler_duty_mode, .pump_up_pulse,
		.pump_dn_pulse, .pfd_delay, .pump_up_gain, .pump_down_gain);
	pcr_host host (.sys_clk, .pin_o(lock_serial_out_pin_o), .pin_oe(lock_serial_out_pin_oe),
		.spi_sclk, .spi_sen, .spi_sdi);
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (ref_clk_tick === 1'b1) ticks++;
		if (cycles == 40000) begin
			n_errors++;
			final_report;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic [23:0] msk(input int a);
		case (a)
			1: msk = 24'h00FFFF;
			2: msk = 24'h000003;
			3: msk = 24'h01FFFF;
			4: msk = 24'h000001;
			5, 6: msk = 24'h000007;
			7: msk = 24'h0003FF;
			default: msk = 24'h000000;
		endcase
	endfunction
	function automatic [23:0] dfl(input int a);
		case (a)
			1: dfl = 24'h00FE9B;
			2: dfl = 24'h000003;
			3: dfl = 24'h008001;
			5: dfl = 24'h000006;
			6: dfl = 24'h000002;
			7: dfl = 24'h000210;
			default: dfl = 24'h000000;
		endcase
	endfunction
	task automatic wr(input int a, input logic [23:0] d);
		host.xfer(1'b0, 6'(a), d, 32, q);
	endtask
	task automatic rd(input int a, input logic [23:0] x);
		host.xfer(1'b1, 6'(a), 24'h000000, 32, q);
		`CHK(q, x)
	endtask
	task automatic edges(input int n);
		repeat (n) begin
			xtal_ref_in = 1'b1;
			repeat (2) @(negedge sys_clk);
			xtal_ref_in = 1'b0;
			repeat (2) @(negedge sys_clk);
		end
	endtask
	task final_report;
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (4) @(negedge sys_clk);
		wr(63, 24'hFFFFFF);
		for (k = 1; k < 8; k++) rd(k, dfl(k));
		rd(0, ID);
		rd(63, 24'h000000);
		for (p = 0; p < 3; p++) begin
			v = pat[p];
			for (k = 1; k < 8; k++) wr(k, v);
			e = v[15:0] & {16{v[1]}};
			g = {v[1], e[0], e[2], e[6:3], e[8] & v[16], e[7] & ~v[16], v[9], e[15:10]};
			`CHK(gv, g)
			`CHK(fv, {v[2:0], v[9:5], v[4:0], v[0]})
			`CHK(lock_serial_out_pin_oe, v[1] & v[0])
			lock_detect_in = 1'b1;
			@(negedge sys_clk);
			`CHK(lock_serial_out_pin_o, e[11])
			lock_detect_in = 1'b0;
			wr(2, 24'h000000);
			for (k = 1; k < 8; k++) rd(k, k == 2 ? 24'h000000 : v & msk(k));
			`CHK(host.rd_oe, 1'b1)
		end
		for (k = 0; k < 5; k++) begin
			wr(1, k == 4 ? 24'h00FE9B : 24'h00FE9F);
			wr(3, r3[k]);
			ticks = 0;
			edges(12);
			repeat (6) @(negedge sys_clk);
			`CHK(ticks, dn[k])
			`CHK(ref_div_used, 1'(dn[k] == 4))
		end
		wr(1, 24'h00FE9B);
		wr(6, 24'h000001);
		for (k = 0; k < 17; k++) begin
			if (k == 16) wr(1, 24'h00EE9B);
			wr(5, k[4] ? 24'h000007 : 24'(k & 7));
			{pfd_up_in, pfd_dn_in} = k[3] ? 2'b01 : 2'b10;
			@(negedge sys_clk);
			{pfd_up_in, pfd_dn_in} = 2'b00;
			g[1:0] = k[4] ? 2'b00 : {k[1] & ~(k[0] ^ k[3]), k[2] & (k[0] ^ k[3])};
			`CHK({pump_up_pulse, pump_dn_pulse}, g[1:0])
			@(negedge sys_clk);
		end
		host.xfer(1'b0, 6'h06, 24'h000005, 30, q);
		rd(6, 24'h000001);
		wr(0, 24'h000001);
		for (k = 1; k < 8; k++) rd(k, dfl(k));
		final_report;
	end
endmodule
`default_nettype wire

// *** include/pcr_defs.vh ***
// register map, field layout, reset values and serial framing for the pll control bank
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH

`define PCR_ADDR_W          6
`define PCR_DATA_W          24
`define PCR_ADDR_STROBE     6'h00
`define PCR_ADDR_ENRST      6'h01
`define PCR_ADDR_DRVFORCE   6'h02
`define PCR_ADDR_REFPATH    6'h03
`define PCR_ADDR_PRESC      6'h04
`define PCR_ADDR_PFD        6'h05
`define PCR_ADDR_PFDDEL     6'h06
`define PCR_ADDR_PUMP       6'h07

`define PCR_ENRST_W         16
`define PCR_DRVFORCE_W      2
`define PCR_REFPATH_W       17
`define PCR_PRESC_W         1
`define PCR_PFD_W           3
`define PCR_PFDDEL_W        3
`define PCR_PUMP_W          10

`define PCR_ENRST_RST       16'hFE9B
`define PCR_DRVFORCE_RST    2'h3
`define PCR_REFPATH_RST     17'h08001
`define PCR_PRESC_RST       1'h0
`define PCR_PFD_RST         3'h6
`define PCR_PFDDEL_RST      3'h2
`define PCR_PUMP_RST        10'h210

`define PCR_EN_VCOBUF       0
`define PCR_EN_BIAS         1
`define PCR_EN_REFDIV       2
`define PCR_EN_XREFMUX_DIG  3
`define PCR_EN_DIVREF_DIG   4
`define PCR_EN_SQR_DIG      5
`define PCR_EN_SIN_DIG      6
`define PCR_EN_SQBUF        7
`define PCR_EN_SINBUF       8
`define PCR_EN_VCO_DIG      9
`define PCR_EN_PRESC        10
`define PCR_EN_LKD_GATE     11
`define PCR_EN_PUMP         12
`define PCR_EN_MOD_RSTN     13
`define PCR_EN_LKD_RSTN     14
`define PCR_EN_SLIP_RSTN    15

`define PCR_DRV_FORCE_VAL   0
`define PCR_DRV_FORCE_EN    1

`define PCR_REF_RATIO_MSB   13
`define PCR_REF_RATIO_W     14
`define PCR_REF_SELECT      14
`define PCR_REF_AUTO        15
`define PCR_REF_SINSEL      16
`define PCR_REF_RATIO_ONE   14'h0001

`define PCR_PFD_INVERT      0
`define PCR_PFD_UP_EN       1
`define PCR_PFD_DN_EN       2

`define PCR_PUMP_UP_MSB     4
`define PCR_PUMP_UP_LSB     0
`define PCR_PUMP_DN_MSB     9
`define PCR_PUMP_DN_LSB     5

`define PCR_STROBE_SWRST    0

`define PCR_ADDR_LAST       3'h5
`define PCR_DATA_LAST       5'h17

`endif

// *** rtl/pcr_bank.v ***
// pll control register bank with serial port slave and derived enables
//
// Notes on behaviour
// R1 - force-enable set: serial-out driver enable follows the force-value bit.
// R2 - force-enable clear: driver enabled only during a serial read, else off.
// R3 - divide reference by ratio bits 13:0 when divider enable and select set.
// R4 - host never writes ratio zero and keeps ratio within 2^14.
// R5 - auto select: bypass divider when ratio is 1, else use it.
// R6 - reference bit 14 selects divided reference, clear bypasses divider.
// R7 - divider enable clear holds divider in reset, same as bypass.
// R8 - enable bit 9 picks modulator clock: divided vco or reference path.
// R9 - modulator runs only while its active-low reset bit 13 is 1.
// R10 - bias enable clear disables the whole synthesizer; code leaves bit 9 clock select and pin driver enable ungated.
// R11 - pump enable bit 12 clear tri-states the pump output.
// R12 - bit 11 enables lock detector and its output gates.
// R13 - bit 14 releases lock detect circuit from reset when 1.
// R14 - bit 15 releases slip-prevention flip-flops, enabling slip prevention.
// R15 - square buffer needs enable and sine-select 0; sine needs sine-select 1.
// R16 - bits 3 to 6 gate reference clocks into the digital logic.
// R17 - polarity bit 0 inverts phase detector polarity.
// R18 - detector bits 1 and 2 pass up and down outputs; clear masks.
// R19 - detector delay is 3 bits at 2:0, reset value 2.
// R20 - pump up and down gains are 5-bit fields at 4:0 and 9:5.
// R21 - duty mode bit lengthens divider low time for large ratios.
// R22 - serial access: read flag, six address bits, 24 data bits, msb first.
// R23 - soft-reset strobe write returns all registers to reset values.
// R24 - bits above each register's fields read zero, writes ignored.
`timescale 1ns/10ps
`default_nettype none
`include "pcr_defs.vh"
module pcr_bank #(
	parameter [23:0] CHIP_ID = 24'h00A5A5 // arbitrary identity value
) (
	input  wire        sys_clk,
	input  wire        rstn,
	input  wire        spi_sclk,
	input  wire        spi_sen,
	input  wire        spi_sdi,
	input  wire        xtal_ref_in,
	input  wire        lock_detect_in,
	input  wire        pfd_up_in,
	input  wire        pfd_dn_in,
	output reg         lock_serial_out_pin_o,
	output wire        lock_serial_out_pin_oe,
	output wire        vco_buffer_enable,
	output wire        bias_enable,
	output wire        ref_div_hold,
	output wire        ref_div_used,
	output reg         ref_clk_tick,
	output wire        xref_mux_gate,
	output wire        div_ref_gate,
	output wire        sq_xtal_gate,
	output wire        sin_xtal_gate,
	output wire        square_buffer_enable,
	output wire        sine_buffer_enable,
	output wire        mod_clk_from_vco,
	output wire        prescaler_enable,
	output wire        lock_detector_enable,
	output wire        pump_output_enable,
	output wire        modulator_run,
	output wire        lock_circuit_enable,
	output wire        cycle_slip_prevention,
	output wire        prescaler_duty_mode,
	output reg         pump_up_pulse,
	output reg         pump_dn_pulse,
	output wire [2:0]  pfd_delay,
	output wire [4:0]  pump_up_gain,
	output wire [4:0]  pump_down_gain
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and edge detect

localparam ST_IDLE = 3'h0;
localparam ST_FLAG = 3'h1;
localparam ST_ADDR = 3'h2;
localparam ST_DATA = 3'h3;
localparam ST_DONE = 3'h4;

wire [3:0] pins_s;
wire       sclk_s = pins_s[0];
wire       sen_s  = pins_s[1];
wire       sdi_s  = pins_s[2];
wire       xref_s = pins_s[3];
reg        sclk_d_r;
reg        xref_d_r;

pcr_sync #(.W(4)) u_sync (
	.sys_clk  (sys_clk),
	.rstn     (rstn),
	.async_in ({xtal_ref_in, spi_sdi, spi_sen, spi_sclk}),
	.sync_out (pins_s)
);

wire sclk_rise = sclk_s & ~sclk_d_r;
wire xref_rise = xref_s & ~xref_d_r;

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		sclk_d_r <= 1'b0;
		xref_d_r <= 1'b0;
	end else begin
		sclk_d_r <= sclk_s;
		xref_d_r <= xref_s;
	end
end

////////////////////////////////////////////////////////////////////////////////
// register storage

reg [`PCR_ENRST_W-1:0]    enrst_r;
reg [`PCR_DRVFORCE_W-1:0] drvforce_r;
reg [`PCR_REFPATH_W-1:0]  refpath_r;
reg [`PCR_PRESC_W-1:0]    presc_r;
reg [`PCR_PFD_W-1:0]      pfd_r;
reg [`PCR_PFDDEL_W-1:0]   pfddel_r;
reg [`PCR_PUMP_W-1:0]     pump_r;

reg [2:0]                 state_r;
reg [2:0]                 state_nxt;
reg [4:0]                 cnt_r;
reg                       rd_r;
reg [`PCR_ADDR_W-1:0]     addr_r;
reg [`PCR_DATA_W-1:0]     sh_r;
reg [`PCR_DATA_W-1:0]     rd_val;

wire                      in_data = (state_r == ST_DATA);
wire                      wr_en   = in_data & sclk_rise & ~rd_r & (cnt_r == `PCR_DATA_LAST);
wire [`PCR_DATA_W-1:0]    wr_word = {sh_r[`PCR_DATA_W-2:0], sdi_s};
wire                      swrst   = wr_en & (addr_r == `PCR_ADDR_STROBE) &
                                    wr_word[`PCR_STROBE_SWRST];

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		enrst_r    <= `PCR_ENRST_RST;
		drvforce_r <= `PCR_DRVFORCE_RST;
		refpath_r  <= `PCR_REFPATH_RST;
		presc_r    <= `PCR_PRESC_RST;
		pfd_r      <= `PCR_PFD_RST;
		pfddel_r   <= `PCR_PFDDEL_RST;
		pump_r     <= `PCR_PUMP_RST;
	end else if (swrst) begin // R23
		enrst_r    <= `PCR_ENRST_RST;
		drvforce_r <= `PCR_DRVFORCE_RST;
		refpath_r  <= `PCR_REFPATH_RST;
		presc_r    <= `PCR_PRESC_RST;
		pfd_r      <= `PCR_PFD_RST;
		pfddel_r   <= `PCR_PFDDEL_RST; // R19
		pump_r     <= `PCR_PUMP_RST;
	end else if (wr_en) begin
		case (addr_r) // R24
		`PCR_ADDR_ENRST: begin
			enrst_r <= wr_word[`PCR_ENRST_W-1:0];
		end
		`PCR_ADDR_DRVFORCE: begin
			drvforce_r <= wr_word[`PCR_DRVFORCE_W-1:0];
		end
		`PCR_ADDR_REFPATH: begin
			refpath_r <= wr_word[`PCR_REFPATH_W-1:0];
		end
		`PCR_ADDR_PRESC: begin
			presc_r <= wr_word[`PCR_PRESC_W-1:0];
		end
		`PCR_ADDR_PFD: begin
			pfd_r <= wr_word[`PCR_PFD_W-1:0];
		end
		`PCR_ADDR_PFDDEL: begin
			pfddel_r <= wr_word[`PCR_PFDDEL_W-1:0];
		end
		`PCR_ADDR_PUMP: begin
			pump_r <= wr_word[`PCR_PUMP_W-1:0];
		end
		default: begin
			pump_r <= pump_r;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// read mux, upper bits zero

always @* begin
	rd_val = {`PCR_DATA_W{1'b0}};
	case (addr_r) // R24
	`PCR_ADDR_STROBE: begin
		rd_val = CHIP_ID;
	end
	`PCR_ADDR_ENRST: begin
		rd_val[`PCR_ENRST_W-1:0] = enrst_r;
	end
	`PCR_ADDR_DRVFORCE: begin
		rd_val[`PCR_DRVFORCE_W-1:0] = drvforce_r;
	end
	`PCR_ADDR_REFPATH: begin
		rd_val[`PCR_REFPATH_W-1:0] = refpath_r;
	end
	`PCR_ADDR_PRESC: begin
		rd_val[`PCR_PRESC_W-1:0] = presc_r;
	end
	`PCR_ADDR_PFD: begin
		rd_val[`PCR_PFD_W-1:0] = pfd_r;
	end
	`PCR_ADDR_PFDDEL: begin
		rd_val[`PCR_PFDDEL_W-1:0] = pfddel_r;
	end
	`PCR_ADDR_PUMP: begin
		rd_val[`PCR_PUMP_W-1:0] = pump_r;
	end
	default: begin
		rd_val = {`PCR_DATA_W{1'b0}};
	end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// serial port framing

always @* begin
	state_nxt = state_r;
	case (state_r) // R22
	ST_IDLE: begin
		if (sen_s)
			state_nxt = ST_FLAG;
	end
	ST_FLAG: begin
		if (sclk_rise)
			state_nxt = ST_ADDR;
	end
	ST_ADDR: begin
		if (sclk_rise && cnt_r[2:0] == `PCR_ADDR_LAST)
			state_nxt = ST_DATA;
	end
	ST_DATA: begin
		if (sclk_rise && cnt_r == `PCR_DATA_LAST)
			state_nxt = ST_DONE;
	end
	ST_DONE: begin
		state_nxt = ST_DONE;
	end
	default: begin
		state_nxt = ST_IDLE;
	end
	endcase
	if (!sen_s)
		state_nxt = ST_IDLE;
end

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		state_r <= ST_IDLE;
		cnt_r   <= 5'h00;
		rd_r    <= 1'b0;
		addr_r  <= {`PCR_ADDR_W{1'b0}};
		sh_r    <= {`PCR_DATA_W{1'b0}};
	end else begin
		state_r <= state_nxt;
		if (state_r == ST_IDLE) begin
			cnt_r <= 5'h00;
			rd_r  <= 1'b0;
		end else if (sclk_rise) begin
			case (state_r) // R22
			ST_FLAG: begin
				rd_r  <= sdi_s;
				cnt_r <= 5'h00;
			end
			ST_ADDR: begin
				addr_r <= {addr_r[`PCR_ADDR_W-2:0], sdi_s};
				cnt_r  <= (cnt_r[2:0] == `PCR_ADDR_LAST) ? 5'h00 : cnt_r + 5'h01;
			end
			ST_DATA: begin
				cnt_r <= cnt_r + 5'h01;
				if (rd_r && cnt_r == 5'h00)
					sh_r <= {rd_val[`PCR_DATA_W-2:0], 1'b0};
				else if (rd_r)
					sh_r <= {sh_r[`PCR_DATA_W-2:0], 1'b0};
				else
					sh_r <= wr_word;
			end
			default: begin
				cnt_r <= cnt_r;
			end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// shared lock-detect / serial-out pin

wire read_active = rd_r & sen_s & (in_data | (state_r == ST_DONE));

assign lock_serial_out_pin_oe = drvforce_r[`PCR_DRV_FORCE_EN] ?
                                drvforce_r[`PCR_DRV_FORCE_VAL] : // R1
                                read_active; // R2

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		lock_serial_out_pin_o <= 1'b0;
	end else if (read_active) begin
		if (in_data && sclk_rise && cnt_r == 5'h00)
			lock_serial_out_pin_o <= rd_val[`PCR_DATA_W-1];
		else if (sclk_rise)
			lock_serial_out_pin_o <= sh_r[`PCR_DATA_W-1];
	end else begin
		lock_serial_out_pin_o <= lock_detect_in & lock_detector_enable;
	end
end

////////////////////////////////////////////////////////////////////////////////
// reference path

wire [`PCR_REF_RATIO_W-1:0] ratio = refpath_r[`PCR_REF_RATIO_MSB:0];
wire                        div_tick;

assign bias_enable  = enrst_r[`PCR_EN_BIAS]; // R10
assign ref_div_hold = ~(enrst_r[`PCR_EN_REFDIV] & bias_enable); // R7
assign ref_div_used = ~ref_div_hold & (refpath_r[`PCR_REF_AUTO] ?
                      (ratio != `PCR_REF_RATIO_ONE) : // R5
                      refpath_r[`PCR_REF_SELECT]); // R6

pcr_refdiv #(.W(`PCR_REF_RATIO_W)) u_refdiv (
	.sys_clk  (sys_clk),
	.rstn     (rstn),
	.hold     (ref_div_hold),
	.ref_tick (xref_rise),
	.ratio    (ratio),
	.div_tick (div_tick)
);

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn)
		ref_clk_tick <= 1'b0;
	else
		ref_clk_tick <= bias_enable & (ref_div_used ? div_tick : xref_rise); // R3
end

////////////////////////////////////////////////////////////////////////////////
// enables and gates

assign vco_buffer_enable     = bias_enable & enrst_r[`PCR_EN_VCOBUF];
assign xref_mux_gate         = bias_enable & enrst_r[`PCR_EN_XREFMUX_DIG]; // R16
assign div_ref_gate          = bias_enable & enrst_r[`PCR_EN_DIVREF_DIG]; // R16
assign sq_xtal_gate          = bias_enable & enrst_r[`PCR_EN_SQR_DIG]; // R16
assign sin_xtal_gate         = bias_enable & enrst_r[`PCR_EN_SIN_DIG]; // R16
assign square_buffer_enable  = bias_enable & enrst_r[`PCR_EN_SQBUF] &
                               ~refpath_r[`PCR_REF_SINSEL]; // R15
assign sine_buffer_enable    = bias_enable & enrst_r[`PCR_EN_SINBUF] &
                               refpath_r[`PCR_REF_SINSEL]; // R15
assign mod_clk_from_vco      = enrst_r[`PCR_EN_VCO_DIG]; // R8
assign prescaler_enable      = bias_enable & enrst_r[`PCR_EN_PRESC];
assign lock_detector_enable  = bias_enable & enrst_r[`PCR_EN_LKD_GATE]; // R12
assign pump_output_enable    = bias_enable & enrst_r[`PCR_EN_PUMP]; // R11
assign modulator_run         = bias_enable & enrst_r[`PCR_EN_MOD_RSTN]; // R9
assign lock_circuit_enable   = bias_enable & enrst_r[`PCR_EN_LKD_RSTN]; // R13
assign cycle_slip_prevention = bias_enable & enrst_r[`PCR_EN_SLIP_RSTN]; // R14
assign prescaler_duty_mode   = presc_r[0]; // R21
assign pfd_delay             = pfddel_r; // R19
assign pump_up_gain          = pump_r[`PCR_PUMP_UP_MSB:`PCR_PUMP_UP_LSB]; // R20
assign pump_down_gain        = pump_r[`PCR_PUMP_DN_MSB:`PCR_PUMP_DN_LSB]; // R20

////////////////////////////////////////////////////////////////////////////////
// phase detector polarity and masking

wire up_pol = pfd_r[`PCR_PFD_INVERT] ? pfd_dn_in : pfd_up_in; // R17
wire dn_pol = pfd_r[`PCR_PFD_INVERT] ? pfd_up_in : pfd_dn_in; // R17

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		pump_up_pulse <= 1'b0;
		pump_dn_pulse <= 1'b0;
	end else begin
		pump_up_pulse <= pump_output_enable & pfd_r[`PCR_PFD_UP_EN] & up_pol; // R18
		pump_dn_pulse <= pump_output_enable & pfd_r[`PCR_PFD_DN_EN] & dn_pol; // R18
	end
end

endmodule
`default_nettype wire

// *** rtl/pcr_refdiv.v ***
// reference divider: one output tick per ratio input ticks, held in reset by hold
`timescale 1ns/10ps
`default_nettype none
module pcr_refdiv #(
	parameter W = 14
) (
	input  wire         sys_clk,
	input  wire         rstn,
	input  wire         hold,
	input  wire         ref_tick,
	input  wire [W-1:0] ratio,
	output reg          div_tick
);

reg [W-1:0] cnt_r;
wire        last = (cnt_r + {{(W-1){1'b0}}, 1'b1}) >= ratio;

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		cnt_r    <= {W{1'b0}};
		div_tick <= 1'b0;
	end else if (hold) begin
		cnt_r    <= {W{1'b0}};
		div_tick <= 1'b0;
	end else if (ref_tick) begin
		div_tick <= last;
		cnt_r    <= last ? {W{1'b0}} : cnt_r + {{(W-1){1'b0}}, 1'b1};
	end else begin
		div_tick <= 1'b0;
	end
end

endmodule
`default_nettype wire

// *** rtl/pcr_sync.v ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module pcr_sync #(
	parameter W = 1
) (
	input  wire         sys_clk,
	input  wire         rstn,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;

always @(posedge sys_clk or negedge rstn) begin
	if (!rstn) begin
		meta_r <= {W{1'b0}};
		sync_r <= {W{1'b0}};
	end else begin
		meta_r <= async_in;
		sync_r <= meta_r;
	end
end

assign sync_out = sync_r;

endmodule
`default_nettype wire
